// ===== rx_descriptor_writeback.sv
// Purpose: Stream-to-memory descriptor fetch, status writeback and tail pause
// Assumes: Data mover and descriptor memory port are simple request/done logic
// Notes:   One descriptor in flight; all control bits are plain ports
//
// How it works
// - Slave error from data path sets status bit 29 and halts gracefully.
// - Decode error on buffer address sets status bit 30 and halts gracefully.
// - Halting error clears run/stop; halted flag rises only after full shutdown.
// - Completed bit 31 written as 1 when the descriptor's transfer finishes.
// - Fetched descriptor with completed bit set is stale: internal fault, halt.
// - With status stream on, status words go into end-of-frame user fields.
// - Non end-of-frame descriptors get zero user fields when stream is on.
// - With status stream off, user fields are left untouched.
// - Length option off: user word four stores status like words zero to three.
// - Length option on: low bits of word four carry total packet byte count.
// - Each descriptor is fetched, transferred, then its status written back.
// - Descriptors run in chain order until the tail one, then processing pauses.
// - Tail write while paused at tail resumes fetching.
// - Tail write while running only moves the pause point.
// - Transferred-bytes field holds actual bytes stored, possibly below length.
`timescale 1ns/1ps
`include "rx_wb_cfg.svh"

module rx_descriptor_writeback #(
    parameter int LEN_WIDTH = `LEN_WIDTH_DEFAULT
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic [31:0] current_descriptor,
    input  wire logic        tail_write,
    input  wire logic [31:0] tail_descriptor_pointer,
    input  wire logic        status_stream_enable,
    input  wire logic        length_in_status_enable,
    output logic             run_stop_bit,
    output logic             engine_halted_flag,
    output logic             sg_internal_fault,
    output logic             paused_at_tail,
    output logic             mem_req,
    output logic             mem_write,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    output logic             mover_start,
    output logic [31:0]      mover_addr,
    output logic [25:0]      mover_length,
    input  wire logic        mover_done,
    input  wire logic [25:0] mover_bytes,
    input  wire logic        mover_eof,
    input  wire logic        mover_sof,
    input  wire logic        data_slave_error,
    input  wire logic        data_decode_error,
    input  wire logic        mover_busy,
    input  wire logic        status_valid,
    output logic             status_ready,
    input  wire logic [31:0] status_data,
    input  wire logic        status_last
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        rx_wb_pkg::phase_type phase;
        logic        run;
        logic        halted;
        logic        fault;
        logic [31:0] tail;
        logic [31:0] desc;
        logic [31:0] next_ptr;
        logic [31:0] buf_addr;
        logic [25:0] buf_len;
        logic [2:0]  word;
        logic        req;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        mstart;
        logic [31:0] status;
        logic        eof;
        logic        err;
        logic [31:0] total;
        logic [2:0]  user_count;
        logic [31:0] user0;
        logic [31:0] user1;
        logic [31:0] user2;
        logic [31:0] user3;
        logic [31:0] user4;
        logic [1:0]  buf_count;
        logic [31:0] buf0;
        logic [31:0] buf1;
        logic        buf0_last;
        logic        buf1_last;
        logic        status_done;
    } state_type;

    state_type r;
    state_type next_r;

    logic        buf_pop;
    logic [31:0] buf_head;
    logic        buf_head_last;

    // Two-entry skid buffer on the status stream: a stall loses no word
    assign status_ready  = (r.buf_count != 2'd2);
    assign buf_head      = r.buf0;
    assign buf_head_last = r.buf0_last;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [31:0] user_sel;
        logic [31:0] len_mask;
        user_sel = 32'h0;
        len_mask = (32'h1 << LEN_WIDTH) - 32'h1;
        next_r   = r;
        next_r.mstart = 1'b0;
        buf_pop  = 1'b0;

        // Status stream capture into user words, across frames
        if (r.buf_count != 2'd0 && !r.status_done) begin
            buf_pop = 1'b1;
            case (r.user_count)
                3'd0: next_r.user0 = buf_head;
                3'd1: next_r.user1 = buf_head;
                3'd2: next_r.user2 = buf_head;
                3'd3: next_r.user3 = buf_head;
                default: next_r.user4 = buf_head;
            endcase
            if (r.user_count < 3'(`USER_WORD_COUNT - 1)) begin
                next_r.user_count = r.user_count + 3'd1;
            end
            if (buf_head_last) begin
                next_r.status_done = 1'b1;
            end
        end
        case ({status_valid && status_ready, buf_pop})
            2'b10: begin
                if (r.buf_count == 2'd0) begin
                    next_r.buf0      = status_data;
                    next_r.buf0_last = status_last;
                end else begin
                    next_r.buf1      = status_data;
                    next_r.buf1_last = status_last;
                end
                next_r.buf_count = r.buf_count + 2'd1;
            end
            2'b01: begin
                next_r.buf0      = r.buf1;
                next_r.buf0_last = r.buf1_last;
                next_r.buf_count = r.buf_count - 2'd1;
            end
            2'b11: begin
                if (r.buf_count == 2'd1) begin
                    next_r.buf0      = status_data;
                    next_r.buf0_last = status_last;
                end else begin
                    next_r.buf0      = r.buf1;
                    next_r.buf0_last = r.buf1_last;
                    next_r.buf1      = status_data;
                    next_r.buf1_last = status_last;
                end
            end
            default: begin
            end
        endcase

        if (tail_write) begin
            next_r.tail = tail_descriptor_pointer;
        end

        case (r.word)
            3'd0: user_sel = r.eof ? r.user0 : 32'h0;
            3'd1: user_sel = r.eof ? r.user1 : 32'h0;
            3'd2: user_sel = r.eof ? r.user2 : 32'h0;
            3'd3: user_sel = r.eof ? r.user3 : 32'h0;
            default: begin
                if (!r.eof) begin
                    user_sel = 32'h0;
                end else if (length_in_status_enable) begin
                    user_sel = (r.user4 & ~len_mask) | (r.total & len_mask);
                end else begin
                    user_sel = r.user4;
                end
            end
        endcase

        case (r.phase)
            rx_wb_pkg::st_idle: begin
                if (start) begin
                    next_r.run    = 1'b1;
                    next_r.halted = 1'b0;
                    next_r.desc   = current_descriptor;
                    next_r.word   = `DESC_NEXT_IDX;
                    next_r.total  = 32'h0;
                    next_r.phase  = rx_wb_pkg::st_fetch_req;
                end
            end
            rx_wb_pkg::st_fetch_req: begin
                next_r.req   = 1'b1;
                next_r.wr    = 1'b0;
                next_r.addr  = r.desc + {27'h0, r.word, 2'b00};
                next_r.phase = rx_wb_pkg::st_fetch_wait;
            end
            rx_wb_pkg::st_fetch_wait: begin
                if (mem_ack) begin
                    next_r.req = 1'b0;
                    case (r.word)
                        `DESC_NEXT_IDX: next_r.next_ptr = mem_rdata;
                        `DESC_BUF_IDX:  next_r.buf_addr = mem_rdata;
                        `DESC_CTRL_IDX: next_r.buf_len  = mem_rdata[25:0];
                        default: begin
                        end
                    endcase
                    if (r.word == `DESC_STATUS_IDX) begin
                        if (mem_rdata[`STAT_CMPLT_BIT]) begin
                            next_r.fault = 1'b1;
                            next_r.run   = 1'b0;
                            next_r.phase = rx_wb_pkg::st_drain;
                        end else begin
                            next_r.mstart = 1'b1;
                            next_r.phase  = rx_wb_pkg::st_xfer;
                        end
                    end else begin
                        next_r.word  = r.word + 3'd1;
                        next_r.phase = rx_wb_pkg::st_fetch_req;
                    end
                end
            end
            rx_wb_pkg::st_xfer: begin
                if (mover_done) begin
                    next_r.status = 32'h0;
                    next_r.status[25:0] = mover_bytes;
                    next_r.status[`STAT_EOF_BIT] = mover_eof;
                    next_r.status[`STAT_SOF_BIT] = mover_sof;
                    next_r.status[`STAT_SLVERR_BIT] = data_slave_error;
                    next_r.status[`STAT_DECERR_BIT] = data_decode_error;
                    next_r.status[`STAT_CMPLT_BIT] = 1'b1;
                    next_r.err   = data_slave_error | data_decode_error;
                    next_r.eof   = mover_eof;
                    next_r.total = r.total + {6'h0, mover_bytes};
                    next_r.word  = `DESC_USER0_IDX;
                    if (!status_stream_enable) begin
                        next_r.phase = rx_wb_pkg::st_status_write;
                    end else begin
                        next_r.phase = mover_eof ? rx_wb_pkg::st_wait_status
                                                 : rx_wb_pkg::st_user_write;
                    end
                end
            end
            rx_wb_pkg::st_wait_status: begin
                // End-of-frame update waits for the whole status packet
                if (r.status_done) begin
                    next_r.phase = rx_wb_pkg::st_user_write;
                end
            end
            rx_wb_pkg::st_user_write: begin
                if (!r.req) begin
                    next_r.req   = 1'b1;
                    next_r.wr    = 1'b1;
                    next_r.addr  = r.desc + 32'h20 + {27'h0, r.word, 2'b00};
                    next_r.wdata = user_sel;
                end else if (mem_ack) begin
                    next_r.req = 1'b0;
                    if (r.word == 3'(`USER_WORD_COUNT - 1)) begin
                        next_r.phase = rx_wb_pkg::st_status_write;
                    end else begin
                        next_r.word = r.word + 3'd1;
                    end
                end
            end
            rx_wb_pkg::st_status_write: begin
                if (!r.req) begin
                    next_r.req   = 1'b1;
                    next_r.wr    = 1'b1;
                    next_r.addr  = r.desc + {27'h0, `DESC_STATUS_IDX, 2'b00};
                    next_r.wdata = r.status;
                end else if (mem_ack) begin
                    next_r.req   = 1'b0;
                    next_r.phase = rx_wb_pkg::st_next;
                    if (r.eof) begin
                        next_r.total       = 32'h0;
                        next_r.status_done = 1'b0;
                        next_r.user_count  = 3'd0;
                    end
                end
            end
            rx_wb_pkg::st_next: begin
                next_r.word = `DESC_NEXT_IDX;
                if (r.err) begin
                    next_r.run   = 1'b0;
                    next_r.phase = rx_wb_pkg::st_drain;
                end else if (r.desc == r.tail) begin
                    next_r.phase = rx_wb_pkg::st_paused;
                end else begin
                    next_r.desc  = r.next_ptr;
                    next_r.phase = rx_wb_pkg::st_fetch_req;
                end
            end
            rx_wb_pkg::st_paused: begin
                if (tail_write) begin
                    next_r.desc  = r.next_ptr;
                    next_r.phase = rx_wb_pkg::st_fetch_req;
                end
            end
            rx_wb_pkg::st_drain: begin
                // Halted is only reported once the mover has gone quiet
                if (!mover_busy && !r.req) begin
                    next_r.halted = 1'b1;
                    next_r.phase  = rx_wb_pkg::st_halted;
                end
            end
            rx_wb_pkg::st_halted: begin
                if (start) begin
                    next_r.fault = 1'b0;
                    next_r.phase = rx_wb_pkg::st_idle;
                end
            end
            default: next_r.phase = rx_wb_pkg::st_idle;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r       <= '0;
            r.phase <= rx_wb_pkg::st_idle;
        end else begin
            r <= next_r;
        end
    end

    assign run_stop_bit       = r.run;
    assign engine_halted_flag = r.halted;
    assign sg_internal_fault  = r.fault;
    assign paused_at_tail     = (r.phase == rx_wb_pkg::st_paused);
    assign mem_req            = r.req;
    assign mem_write          = r.wr;
    assign mem_addr           = r.addr;
    assign mem_wdata          = r.wdata;
    assign mover_start        = r.mstart;
    assign mover_addr         = r.buf_addr;
    assign mover_length       = r.buf_len;

endmodule // rx_descriptor_writeback

// ===== rx_wb_cfg.svh
// Purpose: Constants for the receive descriptor writeback engine
// Assumes: 32-bit descriptor words, byte-addressed descriptor port
// Notes:   Offsets are descriptor word indices
`ifndef RX_WB_CFG_SVH
`define RX_WB_CFG_SVH

`define DESC_NEXT_IDX       3'h0
`define DESC_BUF_IDX        3'h2
`define DESC_CTRL_IDX       3'h6
`define DESC_STATUS_IDX     3'h7
`define DESC_USER0_IDX      3'h0
`define STAT_CMPLT_BIT      31
`define STAT_DECERR_BIT     30
`define STAT_SLVERR_BIT     29
`define STAT_INTERR_BIT     28
`define STAT_EOF_BIT        26
`define STAT_SOF_BIT        27
`define USER_WORD_COUNT     5
`define LEN_WIDTH_DEFAULT   26

`endif

// ===== rx_wb_mem_model.sv
// Purpose: Behavioural memory and data mover facing the engine
// Assumes: Buffer address low bits encode the move result: bytes, eof, sof, slv, dec
// Notes:   Slow mode stretches both memory answers and moves
`timescale 1ns/1ps
module rx_wb_mem_model (
    input  wire logic        clock, rstn, slow, mem_req, mem_write, mover_start,
    input  wire logic [31:0] mem_addr, mem_wdata, mover_addr,
    output logic             mem_ack, mover_done, mover_busy, mover_eof, mover_sof,
    output logic             data_slave_error, data_decode_error,
    output logic [31:0]      mem_rdata,
    output logic [25:0]      mover_bytes
);
logic [31:0] mem [0:511];
logic [11:0] job;
int          wait_cnt, drain;
// Results are garbage outside the done pulse so a late sample shows up
assign mover_bytes = mover_done ? {18'h0, job[7:0]} : ~{18'h0, job[7:0]};
assign {data_decode_error, data_slave_error, mover_sof, mover_eof} =
    mover_done ? job[11:8] : ~job[11:8];
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        {mem_ack, mover_done, mover_busy} <= 3'h0;
        {wait_cnt, drain, mem_rdata, job} <= '0;
    end else begin
        mem_ack <= 1'b0;
        mover_done <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (wait_cnt < (slow ? 3 : 0)) wait_cnt <= wait_cnt + 1;
            else begin
                wait_cnt <= 0;
                mem_ack <= 1'b1;
                if (mem_write) mem[mem_addr[10:2]] <= mem_wdata;
                else mem_rdata <= mem[mem_addr[10:2]];
            end
        end
        // Busy outlasts done by two cycles so drain is really waited for
        if (mover_start) begin
            job <= mover_addr[11:0];
            drain <= slow ? 12 : 5;
            mover_busy <= 1'b1;
        end else if (drain > 0) begin
            drain <= drain - 1;
            mover_done <= drain == 4;
            if (drain == 1) mover_busy <= 1'b0;
        end
    end
end
endmodule // rx_wb_mem_model

// ===== rx_wb_monitor.sv
// Purpose: Port assertions for the receive descriptor writeback engine
// Assumes: Descriptors sit 0x40 apart, status word at offset 0x1c
// Notes:   Bound into every engine instance
`timescale 1ns/1ps
module rx_wb_monitor #(
    parameter int LEN_WIDTH = 26
) (
    input wire logic        clock, rstn, tail_write, status_stream_enable,
    input wire logic        run_stop_bit, engine_halted_flag, sg_internal_fault,
    input wire logic        paused_at_tail, mem_req, mem_write, mem_ack,
    input wire logic [31:0] mem_addr, mem_wdata, mem_rdata,
    input wire logic        mover_start, mover_done, mover_busy,
    input wire logic        data_slave_error, data_decode_error
);
default clocking @(posedge clock); endclocking
default disable iff (!rstn);
////////////////////////////////////////////////////////////////////////////////
logic [1:0] pend;
wire        stat_wr = mem_req && mem_write && mem_addr[5:0] == 6'h1c;
// Error seen with the last move, to be found in the next status write
always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) pend <= 2'h0;
    else if (mover_done) pend <= {data_decode_error, data_slave_error};
end
sequence s_stat_read(bit done);
    mem_req && mem_ack && !mem_write && mem_addr[5:0] == 6'h1c && mem_rdata[31] == done;
endsequence
////////////////////////////////////////////////////////////////////////////////
a_fetch_then_move:
    assert property (s_stat_read(1'b0) |-> ##[1:4] mover_start) else $error("no move after fetch");
a_stale_halts:
    assert property (s_stat_read(1'b1) |-> ##[1:8] (sg_internal_fault && !run_stop_bit))
    else $error("stale descriptor not faulted");
a_stale_no_move:
    assert property (s_stat_read(1'b1) |=> !mover_start [*8]) else $error("stale descriptor moved");
a_status_cmplt:
    assert property (stat_wr |-> mem_wdata[31]) else $error("completed bit not set");
a_error_flags:
    assert property (stat_wr |-> mem_wdata[30:29] == pend) else $error("error flags wrong");
a_error_stops:
    assert property (mover_done && (data_slave_error || data_decode_error) |-> ##[1:80] !run_stop_bit)
    else $error("run not cleared on error");
a_halt_drained:
    assert property ($rose(engine_halted_flag) |-> !mover_busy && !run_stop_bit)
    else $error("halted before shutdown");
a_pause_quiet:
    assert property (paused_at_tail && !tail_write |=> !mem_req) else $error("fetch while paused");
a_tail_resume:
    assert property (paused_at_tail && tail_write |-> ##[1:3] mem_req) else $error("no resume");
a_user_off:
    assert property (!status_stream_enable && mem_req && mem_write |-> mem_addr[5:0] == 6'h1c)
    else $error("user field written while stream off");
a_req_holds:
    assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request dropped");
endmodule // rx_wb_monitor
bind rx_descriptor_writeback rx_wb_monitor #(.LEN_WIDTH(LEN_WIDTH)) i_mon (.*);

// ===== rx_wb_pkg.sv
// Purpose: Types for the receive descriptor writeback engine
// Assumes: Nothing
// Notes:   Constants live in rx_wb_cfg.svh
package rx_wb_pkg;

typedef enum logic [3:0] {
    st_idle,
    st_fetch_req,
    st_fetch_wait,
    st_xfer,
    st_wait_status,
    st_user_write,
    st_status_write,
    st_next,
    st_paused,
    st_drain,
    st_halted
} phase_type;

endpackage

// ===== testbench.sv
// Purpose: Self-checking bench for the receive descriptor writeback engine
// Assumes: Descriptor chain lives in the partner model's memory
// Notes:   Tests are sequences of start, tail and status stream calls
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module testbench;
logic        clock, rstn, start, tail_write, status_stream_enable, length_in_status_enable;
logic        slow, status_valid, status_last, status_ready, run_stop_bit, engine_halted_flag;
logic        sg_internal_fault, paused_at_tail, mem_req, mem_write, mem_ack, mover_start;
logic        mover_done, mover_eof, mover_sof, mover_busy, data_slave_error, data_decode_error;
logic [31:0] current_descriptor, tail_descriptor_pointer, mem_addr, mem_wdata, mem_rdata;
logic [31:0] mover_addr, status_data;
logic [25:0] mover_length, mover_bytes;
int          failures, checks_done;
rx_descriptor_writeback #(.LEN_WIDTH(26)) i_dut (.*);
rx_wb_mem_model i_model (.*);
initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
end
////////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] stat(logic [11:0] j);
    return {1'b1, j[11], j[10], 1'b0, j[9], j[8], 18'h0, j[7:0]};
endfunction
task automatic put(int a, logic [31:0] nxt, logic [11:0] j, logic [31:0] st);
    i_model.mem[a/4] = nxt;
    i_model.mem[a/4+2] = {20'h10000, j};
    i_model.mem[a/4+6] = 32'h100;
    i_model.mem[a/4+7] = st;
    for (int i = 8; i < 13; i++) i_model.mem[a/4+i] = 32'h5a5a_0000 + i;
endtask
task automatic kick(logic [31:0] d);
    @(posedge clock) {start, current_descriptor} <= {1'b1, d};
    @(posedge clock) start <= 1'b0;
endtask
task automatic tail(logic [31:0] t);
    @(posedge clock) {tail_write, tail_descriptor_pointer} <= {1'b1, t};
    @(posedge clock) tail_write <= 1'b0;
endtask
task automatic send(logic [31:0] base);
    for (int i = 0; i < 5; i++) begin
        @(posedge clock) {status_valid, status_data, status_last} <= {1'b1, base + i, i == 4};
        @(negedge clock);
        while (status_ready !== 1'b1) @(negedge clock);
    end
    @(posedge clock) {status_valid, status_data} <= {1'b0, ~base};
endtask
task automatic users(int a, logic [31:0] base, logic [31:0] step, int n);
    for (int i = 0; i < n; i++) `CHK("user word", base + step * i, i_model.mem[a/4+8+i])
endtask
task automatic settle(logic h);
    repeat (3) @(posedge clock);
    if (h) wait (engine_halted_flag === 1'b1);
    else wait (paused_at_tail === 1'b1);
    @(posedge clock);
endtask
task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (20000) @(posedge clock);
    failures++;
    print_verdict();
end
initial begin
    {rstn, start, tail_write, status_valid, status_last, slow} = '0;
    {current_descriptor, tail_descriptor_pointer, status_data} = '0;
    {status_stream_enable, length_in_status_enable} = 2'b10;
    // Chain built before start; last one is stale to provoke the internal fault
    put(32'h000, 32'h040, 12'h210, 0);
    put(32'h040, 32'h080, 12'h108, 0);
    put(32'h080, 32'h0c0, 12'h330, 0);
    put(32'h0c0, 32'h100, 12'h320, 0);
    put(32'h100, 32'h140, 12'h410, 0);
    put(32'h140, 32'h180, 12'h810, 0);
    put(32'h180, 32'h1c0, 12'h310, 32'h8000_0000);
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    #1 `CHK("run", 1'b0, run_stop_bit)
    `CHK("halted", 1'b0, engine_halted_flag)
    tail(32'h040);
    fork send(32'ha0); kick(0); join
    settle(0);
    `CHK("status A", stat(12'h210), i_model.mem[7])
    users(32'h000, 0, 0, 5);
    `CHK("status B", stat(12'h108), i_model.mem[16+7])
    users(32'h040, 32'ha0, 1, 5);
    `CHK("buffer address", 32'h1000_0108, mover_addr)
    `CHK("buffer length", 26'h100, mover_length)
    `CHK("status C held", 32'h0, i_model.mem[32+7])
    {slow, status_stream_enable} <= 2'b10;
    tail(32'h080);
    settle(0);
    `CHK("status C", stat(12'h330), i_model.mem[32+7])
    users(32'h080, 32'h5a5a_0008, 1, 5);
    {slow, status_stream_enable, length_in_status_enable} <= 3'b011;
    fork send(32'hfc00_0001); begin tail(32'h0c0); tail(32'h100); end join
    settle(1);
    users(32'h0c0, 32'hfc00_0001, 1, 4);
    `CHK("user four", 32'hfc00_0020, i_model.mem[48+12])
    `CHK("status E", stat(12'h410), i_model.mem[64+7])
    `CHK("run E", 1'b0, run_stop_bit)
    `CHK("status F held", 32'h0, i_model.mem[80+7])
    kick(0);
    kick(32'h140);
    settle(1);
    `CHK("status F", stat(12'h810), i_model.mem[80+7])
    `CHK("run F", 1'b0, run_stop_bit)
    kick(0);
    kick(32'h180);
    settle(1);
    `CHK("fault", 1'b1, sg_internal_fault)
    `CHK("status G", 32'h8000_0000, i_model.mem[96+7])
    print_verdict();
end
endmodule // testbench
